// ---- core/wave_timer.sv ----
// Purpose: 8-bit timer with one compare channel and four waveform modes
// Assumes: 250 MHz MCLK_IN, classic Wishbone slave, prescaler built in
// Notes: all outputs come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"

module wave_timer
   import timer_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   output logic COMPARE_OUTPUT_PIN_OUT,
   output logic COMPARE_OUTPUT_PIN_OE_OUT,
   output logic OVERFLOW_FLAG_OUT,
   output logic COMPARE_MATCH_FLAG_OUT
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [`PRE_WIDTH-1:0] pre_mask(input logic [2:0] sel);
      case (sel)
         `PRE_SEL8: pre_mask = `PRE_MASK8;
         `PRE_SEL32: pre_mask = `PRE_MASK32;
         `PRE_SEL64: pre_mask = `PRE_MASK64;
         `PRE_SEL128: pre_mask = `PRE_MASK128;
         `PRE_SEL256: pre_mask = `PRE_MASK256;
         default: pre_mask = `PRE_MASK1024;
      endcase
   endfunction

   // Level after a match for select 2 (clear) or 3 (set)
   function automatic logic match_level(input logic [1:0] cos);
      match_level = (cos == `COS_SET);
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   ctrl_t ctrl_reg;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic [7:0] cmp_buf_reg;
   logic [7:0] cmp_act_reg;
   logic [7:0] cmp_act_next;
   count_dir_t dir_reg;
   count_dir_t dir_next;
   logic [`PRE_WIDTH-1:0] pre_reg;
   logic tick;
   logic block_reg;
   logic ovf_reg;
   logic cmp_flag_reg;
   logic oc_reg;
   logic oc_next;
   logic oe_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic req;
   logic wr;
   logic wr_count;
   logic wr_compare;
   logic wr_flags;
   logic is_pwm;
   logic at_max;
   logic at_bottom;
   logic match;
   logic ovf_event;
   logic [1:0] mode;
   logic [1:0] cos;

   assign mode = ctrl_reg.waveform_mode_sel;
   assign cos = ctrl_reg.compare_output_sel;
   assign is_pwm = (mode == `MODE_PHASE_PWM) || (mode == `MODE_FAST_PWM);
   assign at_max = (count_reg == `COUNT_MAX);
   assign at_bottom = (count_reg == `COUNT_BOTTOM);
   assign match = (count_reg == cmp_act_reg) && !block_reg;

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   // One wait state: request taken at first edge, ack at next
   assign req = WB_CYC_IN && WB_STB_IN && !ack_reg;
   assign wr = req && WB_WE_IN && WB_SEL_IN[0];
   assign wr_count = wr && (WB_ADR_IN == `REG_COUNT_ADDR);
   assign wr_compare = wr && (WB_ADR_IN == `REG_COMPARE_ADDR);
   assign wr_flags = wr && (WB_ADR_IN == `REG_FLAGS_ADDR);

   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req;
      end
   end

   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rdata_reg <= 32'h0000_0000;
      end else if (req && !WB_WE_IN) begin
         case (WB_ADR_IN)
            `REG_CTRL_ADDR: rdata_reg <= {23'h00_0000, ctrl_reg};
            `REG_COUNT_ADDR: rdata_reg <= {24'h00_0000, count_reg};
            `REG_COMPARE_ADDR: rdata_reg <= {24'h00_0000, cmp_buf_reg};
            `REG_FLAGS_ADDR: rdata_reg <= {30'h0000_0000, cmp_flag_reg, ovf_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // Mode and output select change at once; never touch the count
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (wr && (WB_ADR_IN == `REG_CTRL_ADDR)) begin
         ctrl_reg[7:0] <= WB_DAT_IN[7:0];
         if (WB_SEL_IN[1]) begin
            ctrl_reg[8] <= WB_DAT_IN[8];
         end
      end
   end

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + `PRE_WIDTH'(1);
      end
   end

   always_comb begin
      if (ctrl_reg.prescale_sel == `PRE_STOP) begin
         tick = 1'b0;
      end else if (ctrl_reg.prescale_sel == `PRE_DIV1) begin
         tick = 1'b1;
      end else begin
         tick = ((pre_reg & pre_mask(ctrl_reg.prescale_sel)) == pre_mask(ctrl_reg.prescale_sel));
      end
   end

   // ----------------------------------------
   // Counter sequence
   // ----------------------------------------
   always_comb begin
      count_next = count_reg + `COUNT_ONE;
      dir_next = dir_reg;
      case (mode)
         `MODE_CLEAR_ON_MATCH: begin
            // Unblocked equality only; a missed top wraps through FF
            if (match) begin
               count_next = `COUNT_BOTTOM;
            end
         end
         `MODE_PHASE_PWM: begin
            if (dir_reg == DIR_UP && at_max) begin
               dir_next = DIR_DOWN;
               count_next = count_reg - `COUNT_ONE;
            end else if (dir_reg == DIR_DOWN && at_bottom) begin
               dir_next = DIR_UP;
            end else if (dir_reg == DIR_DOWN) begin
               count_next = count_reg - `COUNT_ONE;
            end
         end
         default: begin
            // Normal and fast PWM both wrap FF to 00
            dir_next = DIR_UP;
         end
      endcase
   end

   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         count_reg <= `COUNT_RESET;
         dir_reg <= DIR_UP;
      end else if (wr_count) begin
         count_reg <= WB_DAT_IN[7:0];
      end else if (tick) begin
         count_reg <= count_next;
         dir_reg <= dir_next;
      end
   end

   // Held until the next timer tick, even with the prescaler stopped
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         block_reg <= 1'b0;
      end else if (wr_count) begin
         block_reg <= 1'b1;
      end else if (tick) begin
         block_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Compare register and buffer
   // ----------------------------------------
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cmp_buf_reg <= `COMPARE_RESET;
      end else if (wr_compare) begin
         cmp_buf_reg <= WB_DAT_IN[7:0];
      end
   end

   always_comb begin
      cmp_act_next = cmp_act_reg;
      if (!is_pwm) begin
         cmp_act_next = cmp_buf_reg;
      end else if (tick && at_max) begin
         cmp_act_next = cmp_buf_reg;
      end
   end

   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cmp_act_reg <= `COMPARE_RESET;
      end else begin
         cmp_act_reg <= cmp_act_next;
      end
   end

   // ----------------------------------------
   // Flags
   // ----------------------------------------
   always_comb begin
      case (mode)
         `MODE_PHASE_PWM: ovf_event = at_bottom && dir_reg == DIR_DOWN;
         `MODE_FAST_PWM: ovf_event = at_max;
         default: ovf_event = at_max;
      endcase
   end

   // Hardware set wins over a same-cycle write-one clear
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ovf_reg <= 1'b0;
      end else if (tick && ovf_event) begin
         ovf_reg <= 1'b1;
      end else if (wr_flags && WB_DAT_IN[`FLAG_OVF_BIT]) begin
         ovf_reg <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cmp_flag_reg <= 1'b0;
      end else if (tick && match) begin
         cmp_flag_reg <= 1'b1;
      end else if (wr_flags && WB_DAT_IN[`FLAG_CMP_BIT]) begin
         cmp_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Waveform generator
   // ----------------------------------------
   always_comb begin
      oc_next = oc_reg;
      if (cos == `COS_NONE) begin
         oc_next = oc_reg;
      end else if (cos == `COS_TOGGLE) begin
         if (match) begin
            oc_next = !oc_reg;
         end
      end else begin
         case (mode)
            `MODE_FAST_PWM: begin
               // Bottom set beats a match at max: constant level
               if (at_max) begin
                  oc_next = !match_level(cos);
               end else if (match) begin
                  oc_next = match_level(cos);
               end
            end
            `MODE_PHASE_PWM: begin
               if (at_max && dir_reg == DIR_UP) begin
                  // Turning point; new compare is loaded here
                  if (cmp_act_next == `COUNT_MAX) begin
                     oc_next = !match_level(cos);
                  end else begin
                     oc_next = match_level(cos);
                  end
               end else if (match) begin
                  // A match at zero counts as an up match
                  if (dir_reg == DIR_UP || at_bottom) begin
                     oc_next = match_level(cos);
                  end else begin
                     oc_next = !match_level(cos);
                  end
               end
            end
            default: begin
               if (match) begin
                  oc_next = match_level(cos);
               end
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         oc_reg <= 1'b0;
      end else if (tick) begin
         oc_reg <= oc_next;
      end
   end

   // Internal level kept while the pin floats
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= ctrl_reg.pin_dir && (cos != `COS_NONE);
      end
   end

   assign WB_ACK_OUT = ack_reg;
   assign WB_DAT_OUT = rdata_reg;
   assign COMPARE_OUTPUT_PIN_OUT = oc_reg;
   assign COMPARE_OUTPUT_PIN_OE_OUT = oe_reg;
   assign OVERFLOW_FLAG_OUT = ovf_reg;
   assign COMPARE_MATCH_FLAG_OUT = cmp_flag_reg;

endmodule
`default_nettype wire

// ---- core/timer_regs.svh ----
// Purpose: register map, field positions and constants of the waveform timer
// Assumes: 32-bit classic Wishbone, byte addresses, one register per word
// Notes: definitions only
`ifndef WAVE_TIMER_REGS_SVH
`define WAVE_TIMER_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define REG_CTRL_ADDR 8'h00
`define REG_COUNT_ADDR 8'h04
`define REG_COMPARE_ADDR 8'h08
`define REG_FLAGS_ADDR 8'h0C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_WIDTH 9
`define CTRL_RESET 9'h000
`define FLAG_OVF_BIT 0
`define FLAG_CMP_BIT 1
`define COUNT_RESET 8'h00
`define COMPARE_RESET 8'h00
`define COUNT_BOTTOM 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_ONE 8'h01

// ----------------------------------------
// Waveform modes and output actions
// ----------------------------------------
`define MODE_NORMAL 2'h0
`define MODE_PHASE_PWM 2'h1
`define MODE_CLEAR_ON_MATCH 2'h2
`define MODE_FAST_PWM 2'h3
`define COS_NONE 2'h0
`define COS_TOGGLE 2'h1
`define COS_CLEAR 2'h2
`define COS_SET 2'h3

// ----------------------------------------
// Prescaler
// ----------------------------------------
`define PRE_WIDTH 10
`define PRE_STOP 3'h0
`define PRE_DIV1 3'h1
`define PRE_MASK8 10'h007
`define PRE_MASK32 10'h01F
`define PRE_MASK64 10'h03F
`define PRE_MASK128 10'h07F
`define PRE_MASK256 10'h0FF
`define PRE_MASK1024 10'h3FF
`define PRE_SEL8 3'h2
`define PRE_SEL32 3'h3
`define PRE_SEL64 3'h4
`define PRE_SEL128 3'h5
`define PRE_SEL256 3'h6

`endif

// ---- core/timer_pkg.sv ----
// Purpose: types shared by the waveform timer
// Assumes: field layout as in timer_regs.svh
// Notes: control word is carried as one packed struct
package timer_pkg;

   typedef struct packed {
      logic [2:0] prescale_sel;
      logic pin_dir;
      logic spare;
      logic [1:0] compare_output_sel;
      logic [1:0] waveform_mode_sel;
   } ctrl_t;

   typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage

// ---- dv/wave_timer_sva.sv ----
// Purpose: port-level checks for wave_timer
// Assumes: control word shadowed from bus writes
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"
module wave_timer_sva
   import timer_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic WB_ACK_OUT,
   input wire logic COMPARE_OUTPUT_PIN_OUT,
   input wire logic COMPARE_OUTPUT_PIN_OE_OUT,
   input wire logic OVERFLOW_FLAG_OUT,
   input wire logic COMPARE_MATCH_FLAG_OUT
);
   logic take, rd_take, clr_ovf, clr_cmp;
   ctrl_t shadow_reg;
   assign take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
   assign rd_take = take && !WB_WE_IN;
   assign clr_ovf = take && WB_WE_IN && WB_ADR_IN == `REG_FLAGS_ADDR && WB_SEL_IN[0] && WB_DAT_IN[0];
   assign clr_cmp = take && WB_WE_IN && WB_ADR_IN == `REG_FLAGS_ADDR && WB_SEL_IN[0] && WB_DAT_IN[1];
   // Shadow of the control word, kept from bus writes only
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         shadow_reg <= '0;
      end else if (take && WB_WE_IN && WB_ADR_IN == `REG_CTRL_ADDR) begin
         if (WB_SEL_IN[0]) shadow_reg[7:0] <= WB_DAT_IN[7:0];
         if (WB_SEL_IN[1]) shadow_reg[8] <= WB_DAT_IN[8];
      end
   end
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);
   a_ack_pulse: assert property (take |=> WB_ACK_OUT ##1 !WB_ACK_OUT) else $error("ack not one cycle");
   a_ack_cause: assert property ($rose(WB_ACK_OUT) |-> $past(take)) else $error("ack without request");
   a_rd_upper: assert property (WB_ACK_OUT && $past(rd_take) |-> WB_DAT_OUT[31:9] == 23'h0) else $error("upper bits set");
   a_rd_unmapped: assert property ($past(rd_take && WB_ADR_IN > `REG_FLAGS_ADDR) |-> WB_DAT_OUT == 32'h0)
      else $error("unmapped read not zero");
   a_oe_dir: assert property (COMPARE_OUTPUT_PIN_OE_OUT == $past(shadow_reg.pin_dir && shadow_reg.compare_output_sel != 2'h0))
      else $error("pin enable wrong");
   a_ovf_sticky: assert property ($fell(OVERFLOW_FLAG_OUT) |-> $past(clr_ovf)) else $error("overflow lost");
   a_cmp_sticky: assert property ($fell(COMPARE_MATCH_FLAG_OUT) |-> $past(clr_cmp)) else $error("match lost");
   a_stop_no_ovf: assert property ($past(shadow_reg.prescale_sel) == 3'h0 && $past(shadow_reg.prescale_sel, 2) == 3'h0
      |-> !$rose(OVERFLOW_FLAG_OUT)) else $error("overflow while stopped");
   a_stop_pin: assert property ($past(shadow_reg.prescale_sel) == 3'h0 && $past(shadow_reg.prescale_sel, 2) == 3'h0
      |-> $stable(COMPARE_OUTPUT_PIN_OUT)) else $error("pin moved while stopped");
   a_sel0_pin: assert property ($past(shadow_reg.compare_output_sel) == 2'h0
      && $past(shadow_reg.compare_output_sel, 2) == 2'h0 |-> $stable(COMPARE_OUTPUT_PIN_OUT)) else $error("pin moved");
   c_ovf: cover property ($rose(OVERFLOW_FLAG_OUT));
   c_cmp: cover property ($rose(COMPARE_MATCH_FLAG_OUT));
   c_pin: cover property ($rose(COMPARE_OUTPUT_PIN_OUT) && COMPARE_OUTPUT_PIN_OE_OUT);
endmodule
`default_nettype wire

// ---- dv/pin_load.sv ----
// Purpose: load on the compare pin, measures period and high time
// Assumes: pull-down on the line
// Notes: times in clock cycles
`timescale 1ns/1ps
`default_nettype none
module pin_load (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic pin_in,
   input wire logic oe_in,
   output logic line_out,
   output logic [15:0] period_out,
   output logic [15:0] high_out
);
   logic [15:0] now_reg, rise_reg;
   logic prev_reg;
   // Undriven line falls to the pull-down level
   assign line_out = oe_in ? pin_in : 1'b0;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         now_reg <= 16'h0;
         rise_reg <= 16'h0;
         prev_reg <= 1'b0;
         period_out <= 16'h0;
         high_out <= 16'h0;
      end else begin
         now_reg <= now_reg + 16'h1;
         prev_reg <= line_out;
         if (line_out && !prev_reg) begin
            period_out <= now_reg - rise_reg;
            rise_reg <= now_reg;
         end
         if (!line_out && prev_reg) high_out <= now_reg - rise_reg;
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb_waveform_timer_modes.sv ----
// Purpose: self-checking bench for wave_timer
// Assumes: prescaler /1, so one tick per clock
// Notes: waveform cases run from a table
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb_waveform_timer_modes;
   logic clk, rst, cyc, stb, we, ack, pin, oe, ovf, cmpf, line;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r, d;
   logic [15:0] period, high;
   int n_errors = 0;
   int n_tests = 0;
   // ctrl, compare, period, high (period 0: constant level in high)
   logic [8:0] t_ctrl [11] = '{9'h066, 9'h06B, 9'h06F, 9'h06B, 9'h06B, 9'h067, 9'h069, 9'h06D, 9'h069, 9'h069, 9'h04B};
   logic [7:0] t_cmp [11] = '{8'h09, 8'h40, 8'h40, 8'h00, 8'hFF, 8'h40, 8'h40, 8'h40, 8'h00, 8'hFF, 8'h40};
   logic [15:0] t_per [11] = '{16'd20, 16'd256, 16'd256, 16'd256, 16'd0, 16'd512, 16'd510, 16'd510, 16'd0, 16'd0, 16'd0};
   logic [15:0] t_hi [11] = '{16'd10, 16'd65, 16'd191, 16'd1, 16'd1, 16'd256, 16'd128, 16'd382, 16'd0, 16'd1, 16'd0};
   wave_timer i_dut (.MCLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack),
      .COMPARE_OUTPUT_PIN_OUT(pin), .COMPARE_OUTPUT_PIN_OE_OUT(oe), .OVERFLOW_FLAG_OUT(ovf),
      .COMPARE_MATCH_FLAG_OUT(cmpf));
   pin_load i_load (.clk_in(clk), .rst_in(rst), .pin_in(pin), .oe_in(oe), .line_out(line),
      .period_out(period), .high_out(high));
   always #2 clk = ~clk;
   // ----
   // Bus and report tasks
   // ----
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat_w <= v;
      // No limit of its own; the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      d = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic results();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      results();
   end
   // ----
   // Tests
   // ----
   initial begin
      clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; adr = 8'h00; sel = 4'h0; dat_w = 32'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      wb(1, 8'h10, 32'hFF);
      for (int a = 0; a <= 16; a += 4) begin
         wb(0, 8'(a), 32'h0);
         `CHK(d, 32'h0)
      end
      wb(1, 8'h04, 32'hFE);
      wb(1, 8'h0C, 32'h3);
      wb(1, 8'h00, 32'h040);
      repeat (20) @(posedge clk);
      wb(1, 8'h00, 32'h000);
      wb(0, 8'h0C, 32'h0);
      `CHK(d, 32'h3)
      `CHK({cmpf, ovf}, 2'h3)
      wb(0, 8'h04, 32'h0);
      `CHK(d, 32'h15)
      wb(1, 8'h0C, 32'h3);
      wb(0, 8'h0C, 32'h0);
      `CHK(d, 32'h0)
      wb(1, 8'h04, 32'h5A);
      wb(0, 8'h04, 32'h0);
      `CHK(d, 32'h5A)
      wb(1, 8'h08, 32'hA5);
      wb(0, 8'h08, 32'h0);
      `CHK(d, 32'hA5)
      // Count written equal to compare: the first tick must not match
      wb(1, 8'h08, 32'h30);
      wb(1, 8'h04, 32'h30);
      wb(1, 8'h0C, 32'h3);
      wb(1, 8'h00, 32'h040);
      repeat (20) @(posedge clk);
      wb(1, 8'h00, 32'h000);
      wb(0, 8'h0C, 32'h0);
      `CHK(d, 32'h0)
      wb(0, 8'h04, 32'h0);
      `CHK(d, 32'h47)
      for (int i = 0; i < 11; i++) begin
         wb(1, 8'h08, {24'h0, t_cmp[i]});
         wb(1, 8'h00, {23'h0, t_ctrl[i]});
         repeat (1800) @(posedge clk);
         if (t_per[i] != 16'd0) begin
            `CHK(period, t_per[i])
            `CHK(high, t_hi[i])
         end else begin
            repeat (8) begin
               repeat (37) @(posedge clk);
               `CHK(line, t_hi[i][0])
            end
         end
         if (i == 0) begin
            wb(0, 8'h0C, 32'h0);
            `CHK(d, 32'h3)
            wb(1, 8'h0C, 32'h3);
            repeat (300) @(posedge clk);
            wb(0, 8'h0C, 32'h0);
            `CHK(d, 32'h2)
            `CHK({cmpf, ovf}, 2'h2)
         end else begin
            wb(0, 8'h0C, 32'h0);
            `CHK(d, 32'h3)
            `CHK({cmpf, ovf}, 2'h3)
            wb(1, 8'h0C, 32'h3);
         end
      end
      results();
   end
endmodule
bind wave_timer wave_timer_sva i_sva (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN),
   .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
   .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
   .COMPARE_OUTPUT_PIN_OUT(COMPARE_OUTPUT_PIN_OUT), .COMPARE_OUTPUT_PIN_OE_OUT(COMPARE_OUTPUT_PIN_OE_OUT),
   .OVERFLOW_FLAG_OUT(OVERFLOW_FLAG_OUT), .COMPARE_MATCH_FLAG_OUT(COMPARE_MATCH_FLAG_OUT));
`default_nettype wire
